// [design/spi_host_pkg.sv]
// package for the serial control port host controller
// assumes a single 250 MHz system clock domain
package spi_host_pkg;

// ==========================================================
// apb register map of the controller
localparam logic [7:0] CTRL_OFS = 8'h00;
localparam logic [7:0] CMD_OFS = 8'h04;
localparam logic [7:0] STAT_OFS = 8'h08;
localparam logic [7:0] RDATA_OFS = 8'h0C;
localparam logic [7:0] DIV_OFS = 8'h10;

// ctrl fields
localparam int CTRL_CHAIN_BIT = 0;
localparam int CTRL_WIRED_BIT = 1;
// cmd fields: [7:0] data, [14:8] address, [15] read, [23:16] select byte
localparam int CMD_DATA_LSB = 0;
localparam int CMD_ADDR_LSB = 8;
localparam int CMD_READ_BIT = 15;
localparam int CMD_SEL_LSB = 16;
// stat fields
localparam int STAT_BUSY_BIT = 0;
localparam int STAT_DONE_BIT = 1;
localparam int STAT_IRQ_BIT = 2;

// ==========================================================
// reset values and timing
localparam logic [1:0] CTRL_RST = 2'h0;
localparam logic [7:0] DIV_RST = 8'h08;
localparam logic [7:0] DIV_MIN = 8'h02;
localparam int BYTE_BITS = 8;

// ==========================================================
// types
typedef enum logic [2:0] {
	ST_IDLE = 3'b000,
	ST_CSLEAD = 3'b001,
	ST_LOW = 3'b011,
	ST_HIGH = 3'b010,
	ST_CSTAIL = 3'b110
} phase_e;

typedef struct packed {
	logic cs_n;
	logic sclk;
	logic mosi;
	logic mosi_oe;
} spi_pins_s;

typedef struct packed {
	logic [7:0] sel;
	logic read;
	logic [6:0] addr;
	logic [7:0] data;
} spi_cmd_s;

endpackage

// [design/sync2.sv]
// two-flop synchroniser for pins from outside the clock domain
// assumes the input may change at any time relative to clk_sys_in
`timescale 1ns/100ps
module sync2 #(
	parameter int W = 1
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);

// ==========================================================
// state
typedef struct packed {
	logic [W-1:0] s1;
	logic [W-1:0] s2;
} sync_s;

sync_s st_r;
sync_s st_nxt;

always_comb begin
	st_nxt = st_r;
	st_nxt.s1 = d_in;
	st_nxt.s2 = st_r.s1;
end

always_ff @(posedge clk_sys_in or negedge resetn_in) begin
	if (!resetn_in) begin
		st_r <= '0;
	end else begin
		st_r <= st_nxt;
	end
end

assign q_out = st_r.s2;

endmodule

// [design/spi_host.sv]
// apb-controlled host for the four-wire serial control port
// assumes the device samples on rising sclk and drives miso on falling
`timescale 1ns/100ps
// Overview of operation
// - access is command byte then data byte
// - command msb one reads, zero writes
// - low seven command bits carry address
// - write data sent msb first and stored
// - change on falling, sample on rising
// - host idles serial clock high
// - select low before first bit, whole byte
// - wired lines need host tristate on read
// - chain mode adds leading select byte
// - chain bank of eight, one select bit
module spi_host (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic spi_cs_n_out,
	output logic spi_sclk_out,
	output logic spi_mosi_out,
	output logic spi_mosi_oe_out,
	input wire logic spi_miso_in,
	input wire logic dev_int_n_in
);

// ==========================================================
// state
typedef struct packed {
	spi_host_pkg::phase_e ph;
	spi_host_pkg::spi_pins_s pins;
	logic [1:0] ctrl;
	logic [7:0] div;
	logic [7:0] cnt;
	logic [23:0] shreg;
	logic [4:0] bits;
	logic read;
	logic [7:0] rdata;
	logic done;
	logic [31:0] prdata;
} host_s;

host_s st_r;
host_s st_nxt;
logic [1:0] pin_sync;
logic miso_s;
logic int_n_s;
logic wr_acc;
logic busy;
logic data_phase;
spi_host_pkg::spi_cmd_s cmd;

sync2 #(.W(2)) u_sync (
	.clk_sys_in(clk_sys_in),
	.resetn_in(resetn_in),
	.d_in({spi_miso_in, dev_int_n_in}),
	.q_out(pin_sync)
);

assign miso_s = pin_sync[1];
assign int_n_s = pin_sync[0];
assign busy = (st_r.ph != spi_host_pkg::ST_IDLE);
assign wr_acc = psel_in && penable_in && pwrite_in;
assign cmd = pwdata_in[23:0];
// the last eight bits form the data byte
assign data_phase = (st_r.bits <= 5'(spi_host_pkg::BYTE_BITS));

// ==========================================================
// next state
always_comb begin
	st_nxt = st_r;
	if (wr_acc) begin
		if (paddr_in == spi_host_pkg::CTRL_OFS) begin
			st_nxt.ctrl = pwdata_in[1:0];
		end
		// too small a divider would outrun the synchroniser
		if (paddr_in == spi_host_pkg::DIV_OFS && !busy) begin
			st_nxt.div = (pwdata_in[7:0] < spi_host_pkg::DIV_MIN) ?
				spi_host_pkg::DIV_MIN : pwdata_in[7:0];
		end
	end
	// captured in the setup cycle: with pready tied high the data
	// must already stand at the access edge where the master takes it
	if (psel_in && !penable_in && !pwrite_in) begin
		st_nxt.prdata = '0;
		case (paddr_in)
			spi_host_pkg::CTRL_OFS: begin
				st_nxt.prdata[1:0] = st_r.ctrl;
			end
			spi_host_pkg::STAT_OFS: begin
				st_nxt.prdata[spi_host_pkg::STAT_BUSY_BIT] = busy;
				st_nxt.prdata[spi_host_pkg::STAT_DONE_BIT] = st_r.done;
				st_nxt.prdata[spi_host_pkg::STAT_IRQ_BIT] = !int_n_s;
			end
			spi_host_pkg::RDATA_OFS: begin
				st_nxt.prdata[7:0] = st_r.rdata;
			end
			spi_host_pkg::DIV_OFS: begin
				st_nxt.prdata[7:0] = st_r.div;
			end
			default: begin
				st_nxt.prdata = '0;
			end
		endcase
	end
	case (st_r.ph)
		spi_host_pkg::ST_IDLE: begin
			st_nxt.pins.sclk = 1'b1;
			st_nxt.pins.cs_n = 1'b1;
			st_nxt.pins.mosi_oe = 1'b1;
			if (wr_acc && paddr_in == spi_host_pkg::CMD_OFS) begin
				st_nxt.read = cmd.read;
				st_nxt.done = 1'b0;
				st_nxt.cnt = st_r.div;
				if (st_r.ctrl[spi_host_pkg::CTRL_CHAIN_BIT]) begin
					// select byte leads, one bit per device
					st_nxt.shreg = {cmd.sel, cmd.read, cmd.addr,
						cmd.data};
					st_nxt.bits = 5'(3 * spi_host_pkg::BYTE_BITS);
				end else begin
					st_nxt.shreg = {cmd.read, cmd.addr, cmd.data, 8'h00};
					st_nxt.bits = 5'(2 * spi_host_pkg::BYTE_BITS);
				end
				st_nxt.pins.cs_n = 1'b0;
				st_nxt.ph = spi_host_pkg::ST_CSLEAD;
			end
		end
		spi_host_pkg::ST_CSLEAD: begin
			// select settles half a period before the first falling edge
			if (st_r.cnt == 8'h01) begin
				st_nxt.cnt = st_r.div;
				st_nxt.ph = spi_host_pkg::ST_LOW;
				st_nxt.pins.sclk = 1'b0;
				st_nxt.pins.mosi = st_r.shreg[23];
				st_nxt.pins.mosi_oe = !(st_r.read && data_phase &&
					st_r.ctrl[spi_host_pkg::CTRL_WIRED_BIT]);
			end else begin
				st_nxt.cnt = st_r.cnt - 8'h01;
			end
		end
		spi_host_pkg::ST_LOW: begin
			if (st_r.cnt == 8'h01) begin
				st_nxt.cnt = st_r.div;
				st_nxt.pins.sclk = 1'b1;
				st_nxt.ph = spi_host_pkg::ST_HIGH;
			end else begin
				st_nxt.cnt = st_r.cnt - 8'h01;
			end
		end
		spi_host_pkg::ST_HIGH: begin
			if (st_r.cnt == 8'h01) begin
				st_nxt.cnt = st_r.div;
				// sample late in the high phase, past synchroniser delay
				if (st_r.read && data_phase) begin
					st_nxt.rdata = {st_r.rdata[6:0], miso_s};
				end
				st_nxt.shreg = {st_r.shreg[22:0], 1'b0};
				st_nxt.bits = st_r.bits - 5'h01;
				if (st_r.bits == 5'h01) begin
					st_nxt.ph = spi_host_pkg::ST_CSTAIL;
				end else begin
					st_nxt.pins.sclk = 1'b0;
					st_nxt.pins.mosi = st_r.shreg[22];
					st_nxt.pins.mosi_oe = !(st_r.read &&
						st_r.bits <= 5'h09 &&
						st_r.ctrl[spi_host_pkg::CTRL_WIRED_BIT]);
					st_nxt.ph = spi_host_pkg::ST_LOW;
				end
			end else begin
				st_nxt.cnt = st_r.cnt - 8'h01;
			end
		end
		spi_host_pkg::ST_CSTAIL: begin
			if (st_r.cnt == 8'h01) begin
				st_nxt.pins.cs_n = 1'b1;
				st_nxt.pins.mosi_oe = 1'b1;
				st_nxt.done = 1'b1;
				st_nxt.ph = spi_host_pkg::ST_IDLE;
			end else begin
				st_nxt.cnt = st_r.cnt - 8'h01;
			end
		end
		default: begin
			st_nxt.ph = spi_host_pkg::ST_IDLE;
		end
	endcase
end

// ==========================================================
// registers
always_ff @(posedge clk_sys_in or negedge resetn_in) begin
	if (!resetn_in) begin
		st_r <= '0;
		st_r.ph <= spi_host_pkg::ST_IDLE;
		// select and clock idle high, data line driven
		st_r.pins <= 4'hD;
		st_r.ctrl <= spi_host_pkg::CTRL_RST;
		st_r.div <= spi_host_pkg::DIV_RST;
	end else begin
		st_r <= st_nxt;
	end
end

// ==========================================================
// outputs
assign prdata_out = st_r.prdata;
assign pready_out = 1'b1;
assign pslverr_out = 1'b0;
assign spi_cs_n_out = st_r.pins.cs_n;
assign spi_sclk_out = st_r.pins.sclk;
assign spi_mosi_out = st_r.pins.mosi;
assign spi_mosi_oe_out = st_r.pins.mosi_oe;

endmodule

// [dv/spi_host_monitor.sv]
// checker for the host's serial pins
// assumes binding onto spi_host with a divider of 2 or more
`timescale 1ns/100ps
module spi_host_monitor (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic spi_cs_n_out,
	input wire logic spi_sclk_out,
	input wire logic spi_mosi_out,
	input wire logic spi_mosi_oe_out
);
// ==========
// rising sclk edges in the frame
logic [5:0] cnt_r;
always_ff @(posedge clk_sys_in or negedge resetn_in)
	if (!resetn_in) cnt_r <= 6'h00;
	else if (spi_cs_n_out) cnt_r <= 6'h00;
	else if ($rose(spi_sclk_out)) cnt_r <= cnt_r + 6'h01;
default clocking @(posedge clk_sys_in); endclocking
default disable iff (!resetn_in);
// ==========
// properties
property p_idle; spi_cs_n_out |-> spi_sclk_out; endproperty
a_idle: assert property (p_idle) else $error("sclk low idle");
property p_lead; $fell(spi_cs_n_out) |-> spi_sclk_out [*2]; endproperty
a_lead: assert property (p_lead) else $error("no cs lead");
property p_sclk; $changed(spi_sclk_out) |-> !spi_cs_n_out; endproperty
a_sclk: assert property (p_sclk) else $error("sclk off frame");
property p_half; $fell(spi_sclk_out) |-> !spi_sclk_out [*2]; endproperty
a_half: assert property (p_half) else $error("short low");
property p_mosi;
	$changed(spi_mosi_out) |-> $fell(spi_sclk_out) || spi_cs_n_out
		|| $changed(spi_cs_n_out);
endproperty
a_mosi: assert property (p_mosi) else $error("mosi moved");
property p_hold;
	$rose(spi_sclk_out) |-> $stable(spi_mosi_out) ##1 $stable(spi_mosi_out);
endproperty
a_hold: assert property (p_hold) else $error("mosi at rise");
property p_oe; $fell(spi_mosi_oe_out) |-> cnt_r >= 6'h08; endproperty
a_oe: assert property (p_oe) else $error("early release");
property p_tail;
	$rose(spi_cs_n_out) |-> cnt_r == 6'h10 || cnt_r == 6'h18;
endproperty
a_tail: assert property (p_tail) else $error("bad bit count");
endmodule
bind spi_host spi_host_monitor mon (.clk_sys_in, .resetn_in, .spi_cs_n_out,
	.spi_sclk_out, .spi_mosi_out, .spi_mosi_oe_out);

// [dv/spi_dev_model.sv]
// behavioural serial control port device
// assumes a host clocking sclk idle high; status/enable addresses arbitrary
`timescale 1ns/100ps
module spi_dev_model #(
	parameter logic [6:0] STAT_A = 7'h13,
	parameter logic [6:0] EN_A = 7'h16
) (
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic sdi_in,
	input wire logic evt_in,
	output logic sdo_out,
	output logic sdo_oe_out,
	output logic int_n_out,
	output logic serial_pass_through_out
);
logic [7:0] mem [128];
logic [7:0] sh, sel;
logic [6:0] adr;
logic rd, thru_p, thru_q, thru_en;
int n;
wire sl = !mem[0][7] || sel[0];
wire [5:0] b = mem[0][7] ? 6'h08 : 6'h00;
// three status bytes from STAT_A up, one enable byte at EN_A
wire st_hit = adr >= STAT_A && adr <= STAT_A + 7'h02;
initial begin
	foreach (mem[i]) mem[i] = 8'h00;
	sdo_oe_out = 0;
	sdo_out = 0;
end
always @(negedge cs_n_in) begin
	n = 0;
	rd = 0;
	thru_p = 0;
	thru_q = 0;
	thru_en = mem[0][7];
end
// select byte leaves one clock late; the rest passes straight through
always @(negedge sclk_in) if (!cs_n_in) begin
	thru_en = b == 6'h08 && n < 8;
	thru_q = thru_p;
end
assign serial_pass_through_out = thru_en ? thru_q : sdi_in;
always @(posedge cs_n_in) sdo_oe_out = 0;
always @(posedge sclk_in) if (!cs_n_in) begin
	if (!(rd && n >= b + 8)) sh = {sh[6:0], sdi_in};
	thru_p = sdi_in;
	n++;
	if (n == 8 && b == 8) sel = sh;
	if (n == b + 8) {rd, adr} = sh;
	if (n == b + 16 && !rd && sl) begin
		if (st_hit) mem[adr] = mem[adr] & ~sh;
		else mem[adr] = sh;
	end
end
// drive only in a read data byte, so writes leave sdo released
always @(negedge sclk_in) if (!cs_n_in && rd && sl && n >= b + 8) begin
	sh = n == b + 8 ? mem[adr] : sh << 1;
	sdo_oe_out = n < b + 16;
	sdo_out = sh[7];
end
always @(posedge evt_in) if (mem[EN_A][0]) mem[STAT_A][0] = 1;
assign int_n_out = ~|{mem[STAT_A], mem[STAT_A + 7'h01],
	mem[STAT_A + 7'h02]};
endmodule

// [dv/spi_host_tb.sv]
// self-checking bench for spi_host against a device model
// assumes the monitor is bound through its own file
`timescale 1ns/100ps
module spi_host_tb;
logic clk_sys_in = 0, resetn_in = 0, psel_in = 0, penable_in = 0;
logic pwrite_in = 0, evt = 0, wired = 0, flip = 0;
logic [7:0] paddr_in = 8'h00;
logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
logic pready_out, pslverr_out, spi_cs_n_out, spi_sclk_out, spi_miso_in;
logic spi_mosi_out, spi_mosi_oe_out, dev_int_n_in, sdo, soe, thru;
logic [23:0] thru_sh = 24'h000000;
int err_count = 0, n_checks = 0;
// released lines toggle so a stale level never reads back as data
wire line = soe ? sdo : spi_mosi_oe_out ? spi_mosi_out : flip;
assign spi_miso_in = wired ? line : soe ? sdo : flip;
always #2 clk_sys_in = ~clk_sys_in;
always @(posedge clk_sys_in) flip <= ~flip;
spi_host dut (.clk_sys_in, .resetn_in, .psel_in, .penable_in, .pwrite_in,
	.paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
	.spi_cs_n_out, .spi_sclk_out, .spi_mosi_out, .spi_mosi_oe_out,
	.spi_miso_in, .dev_int_n_in);
spi_dev_model dev (.cs_n_in(spi_cs_n_out), .sclk_in(spi_sclk_out),
	.sdi_in(wired ? line : spi_mosi_out), .evt_in(evt), .sdo_out(sdo),
	.sdo_oe_out(soe), .int_n_out(dev_int_n_in),
	.serial_pass_through_out(thru));
// what the next device in the chain would shift in
always @(posedge spi_sclk_out)
	if (!spi_cs_n_out) thru_sh <= {thru_sh[22:0], thru};
task chk(input logic [31:0] g, input logic [31:0] e);
	n_checks++;
	if (g !== e) begin
		err_count++;
		$display("CHECK FAILED %0t got %h want %h", $time, g, e);
	end
endtask
always @(posedge clk_sys_in) if (wired && soe && spi_mosi_oe_out) chk(0, 1);
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	psel_in <= 1;
	pwrite_in <= w;
	paddr_in <= a;
	pwdata_in <= d;
	@(posedge clk_sys_in) penable_in <= 1;
	do @(posedge clk_sys_in); while (pready_out !== 1'b1);
	rd = prdata_out;
	chk({31'h0, pslverr_out}, 0);
	psel_in <= 0;
	penable_in <= 0;
	@(posedge clk_sys_in);
endtask
task xfer(input logic [7:0] s, input logic r, input logic [6:0] a,
	input logic [7:0] d);
	apb(1, spi_host_pkg::CMD_OFS, {8'h00, s, r, a, d});
	do apb(0, spi_host_pkg::STAT_OFS, 0); while (rd[0] !== 1'b0);
	chk({31'h0, rd[spi_host_pkg::STAT_DONE_BIT]}, 1);
	if (r) apb(0, spi_host_pkg::RDATA_OFS, 0);
endtask
task t_regs;
	apb(0, spi_host_pkg::DIV_OFS, 0);
	chk(rd, {24'h0, spi_host_pkg::DIV_RST});
	apb(1, 8'h20, 32'hFF);
	apb(0, 8'h20, 0);
	chk(rd, 0);
	apb(1, spi_host_pkg::DIV_OFS, 32'h1);
	apb(0, spi_host_pkg::DIV_OFS, 0);
	chk(rd, {24'h0, spi_host_pkg::DIV_MIN});
	apb(1, spi_host_pkg::DIV_OFS, 32'h4);
	apb(0, spi_host_pkg::DIV_OFS, 0);
	chk(rd, 32'h4);
	$display("regs done");
endtask
task t_rw;
	for (int i = 0; i < 2; i++) begin
		xfer(0, 0, i ? 7'h7F : 7'h05, i ? 8'h5A : 8'hA5);
		xfer(0, 1, i ? 7'h7F : 7'h05, 0);
		chk(rd, i ? 32'h5A : 32'hA5);
	end
	$display("rw done");
endtask
task t_wired;
	apb(1, spi_host_pkg::CTRL_OFS, 32'h2);
	apb(0, spi_host_pkg::CTRL_OFS, 0);
	chk(rd, 32'h2);
	wired <= 1;
	xfer(0, 0, 7'h1E, 8'hC3);
	xfer(0, 1, 7'h1E, 0);
	chk(rd, 32'hC3);
	apb(1, spi_host_pkg::CTRL_OFS, 0);
	wired <= 0;
	$display("wired done");
endtask
task t_irq;
	for (int i = 0; i < 2; i++) begin
		evt <= 1;
		@(posedge clk_sys_in) evt <= 0;
		repeat (4) @(posedge clk_sys_in);
		apb(0, spi_host_pkg::STAT_OFS, 0);
		chk({31'h0, rd[2]}, i);
		xfer(0, 0, 7'h16, 8'h01);
	end
	xfer(0, 0, 7'h13, 8'h00);
	xfer(0, 1, 7'h13, 0);
	chk(rd, 1);
	xfer(0, 0, 7'h13, 8'h01);
	apb(0, spi_host_pkg::STAT_OFS, 0);
	chk({31'h0, rd[2]}, 0);
	$display("irq done");
endtask
task t_chain;
	xfer(0, 0, 7'h00, 8'h80);
	apb(1, spi_host_pkg::CTRL_OFS, 32'h1);
	xfer(8'h01, 0, 7'h06, 8'h77);
	xfer(8'h02, 0, 7'h06, 8'h11);
	chk({8'h00, thru_sh}, 32'h00010611);
	xfer(8'h01, 1, 7'h06, 0);
	chk(rd, 32'h77);
	xfer(8'h01, 0, 7'h00, 8'h00);
	$display("chain done");
endtask
task finish_test;
	$display("checks %0d mismatches %0d", n_checks, err_count);
	if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
	else $display("TEST FAILED");
	$finish;
endtask
initial begin
	repeat (10) @(posedge clk_sys_in);
	resetn_in <= 1;
	@(posedge clk_sys_in);
	t_regs;
	t_rw;
	t_wired;
	t_irq;
	t_chain;
	finish_test;
end
initial begin
	#200000;
	err_count++;
	finish_test;
end
endmodule
